/* design/tsc_pkg.sv */
/*
 * Package of the touch status and control register bank: register
 * offsets, field positions, reset values and operating mode codes.
 * Assumes a byte-wide register port driven by a two-wire slave front end.
 */
package tsc_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] TSC_OFS_IRQ_SRC   = 8'h00;
    localparam logic [7:0] TSC_OFS_WHL_STAT  = 8'h01;
    localparam logic [7:0] TSC_OFS_BTN_STAT  = 8'h02;
    localparam logic [7:0] TSC_OFS_POS_HIGH  = 8'h03;
    localparam logic [7:0] TSC_OFS_POS_LOW   = 8'h04;
    localparam logic [7:0] TSC_OFS_PIN_STAT  = 8'h07;
    localparam logic [7:0] TSC_OFS_PARM_STAT = 8'h08;
    localparam logic [7:0] TSC_OFS_COMP_MODE = 8'h09;
    localparam logic [7:0] TSC_OFS_OUT_CTRL  = 8'h0a;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int TSC_IRQ_BURN   = 6;
    localparam int TSC_IRQ_PWRITE = 5;
    localparam int TSC_IRQ_PIN    = 4;
    localparam int TSC_IRQ_WHEEL  = 3;
    localparam int TSC_IRQ_BUTTON = 2;
    localparam int TSC_IRQ_COMP   = 1;
    localparam int TSC_IRQ_MODE   = 0;
    localparam int TSC_WHL_CW     = 6;
    localparam int TSC_WHL_CCW    = 5;
    localparam int TSC_WHL_TOUCH  = 4;
    localparam int TSC_PRM_VALID  = 3;
    localparam int TSC_COMP_RUN   = 2;

    // ****************************************************************
    // reset values and codes
    // ****************************************************************
    localparam logic [7:0] TSC_RST_BYTE    = 8'h00;
    localparam logic [2:0] TSC_BURN_MAX    = 3'h4;
    localparam logic [1:0] TSC_MODE_ACTIVE = 2'h0;
    localparam logic [1:0] TSC_MODE_DOZE   = 2'h1;
    localparam logic [1:0] TSC_MODE_SLEEP  = 2'h2;
    localparam logic [1:0] TSC_MODE_RSVD   = 2'h3;

    typedef enum logic [1:0] {
        TSC_ACTIVE,
        TSC_DOZE,
        TSC_SLEEP
    } tsc_mode_t;

endpackage

/* design/tsc_pin_edge.sv */
/*
 * Input pin edge detector for the touch register bank.
 * Assumes pin levels already synchronous to clk_in.
 */
`timescale 1ns/1ps
module tsc_pin_edge
    import tsc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] level_in,
    input  wire logic [WIDTH-1:0] is_input_in,
    input  wire logic [WIDTH-1:0] rise_sel_in,
    input  wire logic [WIDTH-1:0] fall_sel_in,
    output logic                  edge_out
);

    logic [WIDTH-1:0] last_ff;
    logic             primed_ff;
    logic [WIDTH-1:0] hit;

    // the first level after reset only seeds the history, so a pin that
    // idles high raises no false edge once reset lets go
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_ff   <= '0;
            primed_ff <= 1'b0;
        end else begin
            last_ff   <= level_in;
            primed_ff <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            assign hit[i] = primed_ff & is_input_in[i] &
                ((rise_sel_in[i] & level_in[i] & ~last_ff[i]) |
                 (fall_sel_in[i] & ~level_in[i] & last_ff[i]));
        end
    endgenerate

    assign edge_out = |hit;

endmodule

/* design/tsc_regs.sv */
/*
 * Host-visible status and control register bank of a capacitive touch
 * controller. Holds the interrupt source register, wheel and button
 * status, wheel position, pin status, parameter memory status, the
 * compensation/mode register and the output pin control register.
 * Assumes a byte-wide register port from a two-wire slave front end:
 * one-cycle read and write strobes with an address, synchronous to clk_in.
 * Sensing events arrive as one-cycle pulses from the sensing engine.
 */
`timescale 1ns/1ps
module tsc_regs
    import tsc_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    // register port
    input  wire logic [7:0]      reg_addr_in,
    input  wire logic            reg_wr_in,
    input  wire logic [7:0]      reg_wdata_in,
    input  wire logic            reg_rd_in,
    output logic [7:0]           reg_rdata_out,
    output logic                 interrupt_line_n_out,
    // sensing engine
    input  wire logic            phase_start_in,
    input  wire logic            burn_done_in,
    input  wire logic            param_write_done_in,
    input  wire logic            wheel_event_in,
    input  wire logic            button_event_in,
    input  wire logic            button_report_en_in,
    input  wire logic            comp_done_in,
    input  wire logic            comp_running_in,
    input  wire logic            mode_entered_in,
    input  wire logic [1:0]      mode_current_in,
    input  wire logic            wheel_cw_in,
    input  wire logic            wheel_ccw_in,
    input  wire logic            wheel_touched_in,
    input  wire logic [7:0]      button_touched_in,
    input  wire logic [15:0]     wheel_position_in,
    input  wire logic            burned_params_valid_in,
    input  wire logic [2:0]      burn_count_in,
    // pins and parameters
    input  wire logic [PINS-1:0] input_pin_in,
    input  wire logic [PINS-1:0] pin_is_input_in,
    input  wire logic [PINS-1:0] pin_is_output_in,
    input  wire logic [PINS-1:0] edge_rise_sel_in,
    input  wire logic [PINS-1:0] edge_fall_sel_in,
    input  wire logic [PINS-1:0] output_powerup_state_in,
    input  wire logic            auto_light_in,
    input  wire logic [7:0]      on_level_in,
    input  wire logic [7:0]      off_level_in,
    // applied controls
    output logic                 comp_start_out,
    output logic [1:0]           mode_request_out,
    output logic [PINS-1:0]      output_pin_on_out,
    output logic [7:0]           output_pin_level_out [PINS]
);

    initial begin
        if (PINS < 1 || PINS > 8) begin
            $error("PINS must lie between 1 and 8");
        end
    end

    // ****************************************************************
    // interrupt source
    // ****************************************************************
    logic [7:0] irq_ff;
    logic [7:0] nxt_irq;
    logic       pin_edge;
    logic       rd_irq;

    tsc_pin_edge #(.WIDTH(PINS)) u_edge (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .level_in    (input_pin_in),
        .is_input_in (pin_is_input_in),
        .rise_sel_in (edge_rise_sel_in),
        .fall_sel_in (edge_fall_sel_in),
        .edge_out    (pin_edge)
    );

    assign rd_irq = reg_rd_in && (reg_addr_in == TSC_OFS_IRQ_SRC);

    always_comb begin
        nxt_irq = irq_ff;
        if (rd_irq) begin
            nxt_irq = TSC_RST_BYTE;
        end
        // events win over a clearing read in the same cycle
        if (burn_done_in)        nxt_irq[TSC_IRQ_BURN]   = 1'b1;
        if (param_write_done_in) nxt_irq[TSC_IRQ_PWRITE] = 1'b1;
        if (pin_edge)            nxt_irq[TSC_IRQ_PIN]    = 1'b1;
        if (wheel_event_in)      nxt_irq[TSC_IRQ_WHEEL]  = 1'b1;
        if (button_event_in && button_report_en_in) begin
            nxt_irq[TSC_IRQ_BUTTON] = 1'b1;
        end
        if (comp_done_in)        nxt_irq[TSC_IRQ_COMP]   = 1'b1;
        if (mode_entered_in &&
            (mode_current_in == TSC_MODE_ACTIVE ||
             mode_current_in == TSC_MODE_DOZE)) begin
            nxt_irq[TSC_IRQ_MODE] = 1'b1;
        end
        nxt_irq[7] = 1'b0;
    end

    // events are taken as the engine reports them, which may lag by a scan
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_ff <= TSC_RST_BYTE;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign interrupt_line_n_out = ~(|irq_ff);

    // ****************************************************************
    // host controls, applied at the next processing phase; output pins only while auto_light_in is low
    // ****************************************************************
    logic [1:0]      mode_wr_ff;
    logic            comp_req_ff;
    logic [PINS-1:0] out_ctrl_ff;
    logic            ctrl_seeded_ff;
    logic            wr_mode;
    logic            wr_out;

    assign wr_mode = reg_wr_in && (reg_addr_in == TSC_OFS_COMP_MODE);
    assign wr_out  = reg_wr_in && (reg_addr_in == TSC_OFS_OUT_CTRL);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_wr_ff <= TSC_MODE_ACTIVE;
        end else if (wr_mode && reg_wdata_in[1:0] != TSC_MODE_RSVD) begin
            mode_wr_ff <= reg_wdata_in[1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comp_req_ff <= 1'b0;
        end else if (wr_mode && reg_wdata_in[TSC_COMP_RUN]) begin
            comp_req_ff <= 1'b1;
        end else if (phase_start_in) begin
            comp_req_ff <= 1'b0;
        end
    end

    // powerup state is caught after reset release, not under the reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_seeded_ff <= 1'b0;
            out_ctrl_ff    <= '0;
        end else if (!ctrl_seeded_ff) begin
            ctrl_seeded_ff <= 1'b1;
            out_ctrl_ff    <= output_powerup_state_in;
        end else if (wr_out) begin
            out_ctrl_ff    <= reg_wdata_in[PINS-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comp_start_out   <= 1'b0;
            mode_request_out <= TSC_MODE_ACTIVE;
        end else begin
            comp_start_out <= phase_start_in & comp_req_ff;
            if (phase_start_in) begin
                mode_request_out <= mode_wr_ff;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            output_pin_on_out <= '0;
        end else if (phase_start_in && !auto_light_in) begin
            output_pin_on_out <= out_ctrl_ff & pin_is_output_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_level
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    output_pin_level_out[g] <= TSC_RST_BYTE;
                end else begin
                    output_pin_level_out[g] <= output_pin_on_out[g] ?
                        on_level_in : off_level_in;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // status snapshot and read mux
    // ****************************************************************
    logic [15:0] pos_ff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos_ff <= 16'h0000;
        end else if (wheel_touched_in) begin
            pos_ff <= wheel_position_in;
        end
    end

    function automatic logic [7:0] pad_pins(input logic [PINS-1:0] v);
        logic [7:0] r;
        r = '0;
        r[PINS-1:0] = v;
        return r;
    endfunction

    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = TSC_RST_BYTE;
        unique case (reg_addr_in)
            TSC_OFS_IRQ_SRC:   rd_mux = irq_ff;
            TSC_OFS_WHL_STAT: begin
                rd_mux[TSC_WHL_CW]    = wheel_cw_in;
                rd_mux[TSC_WHL_CCW]   = wheel_ccw_in;
                rd_mux[TSC_WHL_TOUCH] = wheel_touched_in;
            end
            TSC_OFS_BTN_STAT:  rd_mux = button_touched_in;
            TSC_OFS_POS_HIGH:  rd_mux = pos_ff[15:8];
            TSC_OFS_POS_LOW:   rd_mux = pos_ff[7:0];
            TSC_OFS_PIN_STAT:
                rd_mux = pad_pins(input_pin_in & pin_is_input_in);
            TSC_OFS_PARM_STAT: begin
                rd_mux[TSC_PRM_VALID] = burned_params_valid_in;
                rd_mux[2:0] = (burn_count_in > TSC_BURN_MAX) ?
                    TSC_BURN_MAX : burn_count_in;
            end
            TSC_OFS_COMP_MODE: begin
                rd_mux[TSC_COMP_RUN] = comp_running_in | comp_req_ff;
                rd_mux[1:0] = mode_wr_ff;
            end
            TSC_OFS_OUT_CTRL:  rd_mux = pad_pins(out_ctrl_ff);
            default:           rd_mux = TSC_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= TSC_RST_BYTE;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_irq_read;
        rd_irq && !burn_done_in && !param_write_done_in && !pin_edge &&
        !wheel_event_in && !button_event_in && !comp_done_in &&
        !mode_entered_in;
    endsequence

    // a pending request with no rewrite in the same cycle
    sequence s_comp_due;
        comp_req_ff && phase_start_in && !wr_mode;
    endsequence

    AST_LINE_LOW: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (|irq_ff) |-> !interrupt_line_n_out)
        else $error("interrupt line high with a flag set");
    AST_READ_CLEARS: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_irq_read |=> interrupt_line_n_out)
        else $error("interrupt read did not clear");
    AST_BURN: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        burn_done_in |=> irq_ff[TSC_IRQ_BURN])
        else $error("burn flag not set");
    AST_PWRITE: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        param_write_done_in |=> irq_ff[TSC_IRQ_PWRITE])
        else $error("parameter write flag not set");
    AST_PIN: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        pin_edge |=> irq_ff[TSC_IRQ_PIN])
        else $error("pin edge flag not set");
    AST_WHEEL: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        wheel_event_in |=> irq_ff[TSC_IRQ_WHEEL])
        else $error("wheel flag not set");
    AST_BUTTON: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (button_event_in && button_report_en_in) |=> irq_ff[TSC_IRQ_BUTTON])
        else $error("button flag not set");
    AST_COMP: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        comp_done_in |=> irq_ff[TSC_IRQ_COMP])
        else $error("compensation flag not set");
    AST_COMP_START: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_comp_due |=> (comp_start_out && !comp_req_ff))
        else $error("compensation not started at phase");
    AST_MODE_HELD: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !$past(phase_start_in) |-> $stable(mode_request_out))
        else $error("mode applied outside a phase start");

endmodule

/* tb/tsc_host_model.sv */
/*
 * Host model of the register port: byte writes and reads with one-cycle
 * strobes, and a bounded wait on the interrupt line.
 * Assumes the bank takes a strobe at the rising edge of clk_in.
 */
`timescale 1ns/1ps
module tsc_host_model
    import tsc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       interrupt_line_n_in,
    output logic [7:0]      reg_addr_out,
    output logic            reg_wr_out,
    output logic [7:0]      reg_wdata_out,
    output logic            reg_rd_out
);
    // ****************************************************************
    // bus tasks
    // ****************************************************************
    initial begin
        reg_addr_out  = 8'h00;
        reg_wr_out    = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out    = 1'b0;
    end

    // released lines show the inverse so stale values never pass
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= (a == TSC_OFS_COMP_MODE) ? (d & 8'h07) : d;
        reg_wr_out    <= 1'b1;
        @(posedge clk_in);
        reg_wr_out    <= 1'b0;
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_rd_out   <= 1'b1;
        @(posedge clk_in);
        reg_rd_out   <= 1'b0;
        reg_addr_out <= ~a;
        #1;
        d = reg_rdata_in;
    endtask

    // no read after a change to active or doze mode until the line drops
    task automatic wait_irq(input int bound, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < bound && !ok; i++) begin
            @(posedge clk_in);
            #1;
            ok = (interrupt_line_n_in === 1'b0);
        end
    endtask
endmodule

/* tb/tsc_regs_tb_top.sv */
/*
 * Self-checking testbench of the touch status and control register bank.
 * Assumes the host model drives the register port; the bench plays the
 * sensing engine and the pin parameters.
 */
`timescale 1ns/1ps
module tsc_regs_tb_top
    import tsc_pkg::*;
;
    // ****************************************************************
    // stimulus signals
    // ****************************************************************
    logic       clk_in, rst_n_in, phs, ben, crun, wcw, wccw, wtch;
    logic       pval, auto_l, irq_n, cstart;
    logic [6:0] evt;
    logic [1:0] mcur, mreq;
    logic [7:0] addr, wdat, rdat, btn, pins, on_out, rd_v;
    logic [7:0] rsel, fsel, pmask;
    logic       wr, rd;
    logic [15:0] wpos;
    logic [2:0] bcnt;
    logic [7:0] lvl [8];
    int         fail_count;
    int         num_checks;
    bit         ok;
    logic [7:0] zero_ofs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
        8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0f};

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    tsc_host_model u_tsc_host_model (
        .clk_in(clk_in), .reg_rdata_in(rdat), .interrupt_line_n_in(irq_n),
        .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdat),
        .reg_rd_out(rd));

    tsc_regs #(.PINS(8)) u_tsc_regs (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdat), .reg_rd_in(rd),
        .reg_rdata_out(rdat), .interrupt_line_n_out(irq_n),
        .phase_start_in(phs), .burn_done_in(evt[6]),
        .param_write_done_in(evt[5]), .wheel_event_in(evt[3]),
        .button_event_in(evt[2]), .button_report_en_in(ben),
        .comp_done_in(evt[1]), .comp_running_in(crun),
        .mode_entered_in(evt[0]), .mode_current_in(mcur),
        .wheel_cw_in(wcw), .wheel_ccw_in(wccw), .wheel_touched_in(wtch),
        .button_touched_in(btn), .wheel_position_in(wpos),
        .burned_params_valid_in(pval), .burn_count_in(bcnt),
        .input_pin_in(pins), .pin_is_input_in(pmask),
        .pin_is_output_in(8'h3f), .edge_rise_sel_in(rsel),
        .edge_fall_sel_in(fsel), .output_powerup_state_in(8'h5a),
        .auto_light_in(auto_l), .on_level_in(8'hee), .off_level_in(8'h11),
        .comp_start_out(cstart), .mode_request_out(mreq),
        .output_pin_on_out(on_out), .output_pin_level_out(lvl));

    // ****************************************************************
    // helper tasks
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        u_tsc_host_model.rd_reg(a, rd_v);
        check($sformatf("register %h", a), {8'h00, rd_v}, {8'h00, exp});
    endtask

    // the pin edge travels through the pin levels, not a pulse
    task automatic fire(input logic [6:0] m);
        @(posedge clk_in);
        evt <= m & 7'h6f;
        if (m[4]) pins <= pins ^ 8'h01;
        @(posedge clk_in);
        evt <= 7'h00;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic phase();
        @(posedge clk_in);
        phs <= 1'b1;
        @(posedge clk_in);
        phs <= 1'b0;
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        end_of_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n_in, phs, ben, crun, wcw, wccw, wtch, pval, auto_l} = '0;
        {evt, mcur, btn, pins, wpos, bcnt} = '0;
        {pmask, rsel, fsel} = {8'h0f, 8'h01, 8'h00};
        fail_count = 0;
        num_checks = 0;
        ben = 1'b1;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        check("line after reset", {15'h0, irq_n}, 16'h1);
        foreach (zero_ofs[i]) rc(zero_ofs[i], 8'h00);
        rc(TSC_OFS_OUT_CTRL, 8'h5a);
        for (int b = 0; b < 7; b++) begin
            fire(7'h01 << b);
            check("line set", {15'h0, irq_n}, 16'h0);
            rc(TSC_OFS_IRQ_SRC, 8'h01 << b);
            check("line clear", {15'h0, irq_n}, 16'h1);
            rc(TSC_OFS_IRQ_SRC, 8'h00);
        end
        @(posedge clk_in);
        {rsel, fsel} <= {8'h00, 8'h01};
        fire(7'h10);
        rc(TSC_OFS_IRQ_SRC, 8'h10);
        fire(7'h10);
        rc(TSC_OFS_IRQ_SRC, 8'h00);
        fire(7'h4a);
        rc(TSC_OFS_IRQ_SRC, 8'h4a);
        @(posedge clk_in);
        ben <= 1'b0;
        mcur <= TSC_MODE_SLEEP;
        fire(7'h05);
        rc(TSC_OFS_IRQ_SRC, 8'h00);
        check("line idle", {15'h0, irq_n}, 16'h1);
        @(posedge clk_in);
        {wcw, wtch, btn, wpos, pins, pval, bcnt} <= {2'b11, 8'ha5,
            16'h1234, 8'ha5, 1'b1, 3'h3};
        repeat (3) @(posedge clk_in);
        rc(TSC_OFS_WHL_STAT, 8'h50);
        rc(TSC_OFS_BTN_STAT, 8'ha5);
        rc(TSC_OFS_PIN_STAT, 8'h05);
        @(posedge clk_in);
        pmask <= 8'hf0;
        rc(TSC_OFS_PIN_STAT, 8'ha0);
        rc(TSC_OFS_PARM_STAT, 8'h0b);
        @(posedge clk_in);
        {wcw, wccw} <= 2'b01;
        repeat (3) @(posedge clk_in);
        rc(TSC_OFS_WHL_STAT, 8'h30);
        @(posedge clk_in);
        {wccw, wtch, wpos, bcnt, pval} <= {2'b00, 16'hffff, 3'h7, 1'b0};
        repeat (3) @(posedge clk_in);
        rc(TSC_OFS_POS_HIGH, 8'h12);
        rc(TSC_OFS_POS_LOW, 8'h34);
        rc(TSC_OFS_WHL_STAT, 8'h00);
        rc(TSC_OFS_PARM_STAT, 8'h04);
        u_tsc_host_model.wr_reg(TSC_OFS_COMP_MODE, 8'hfc);
        rc(TSC_OFS_COMP_MODE, 8'h04);
        check("start held", {15'h0, cstart}, 16'h0);
        phase();
        check("start pulse", {15'h0, cstart}, 16'h1);
        @(posedge clk_in);
        #1;
        check("start drop", {15'h0, cstart}, 16'h0);
        fire(7'h02);
        rc(TSC_OFS_COMP_MODE, 8'h00);
        rc(TSC_OFS_IRQ_SRC, 8'h02);
        @(posedge clk_in);
        crun <= 1'b1;
        rc(TSC_OFS_COMP_MODE, 8'h04);
        @(posedge clk_in);
        crun <= 1'b0;
        // reads after entering active or doze wait for the line first
        for (int m = 2; m >= 0; m--) begin
            u_tsc_host_model.wr_reg(TSC_OFS_COMP_MODE, 8'(m));
            u_tsc_host_model.wr_reg(TSC_OFS_COMP_MODE, 8'h03);
            phase();
            check("mode request", {14'h0, mreq}, 16'(m));
            if (2'(m) != TSC_MODE_SLEEP) begin
                @(posedge clk_in);
                mcur <= 2'(m);
                fire(7'h01);
                u_tsc_host_model.wait_irq(20, ok);
                check("mode entry line", {15'h0, ok}, 16'h1);
                if (!ok) end_of_test();
                rc(TSC_OFS_IRQ_SRC, 8'h01);
            end
            rc(TSC_OFS_COMP_MODE, 8'(m));
        end
        check("outputs before phase", {8'h0, on_out}, 16'h001a);
        u_tsc_host_model.wr_reg(TSC_OFS_OUT_CTRL, 8'hc3);
        phase();
        check("outputs applied", {8'h0, on_out}, 16'h0003);
        rc(TSC_OFS_OUT_CTRL, 8'hc3);
        @(posedge clk_in);
        #1;
        check("on level", {8'h0, lvl[0]}, 16'h00ee);
        check("off level", {8'h0, lvl[2]}, 16'h0011);
        @(posedge clk_in);
        auto_l <= 1'b1;
        u_tsc_host_model.wr_reg(TSC_OFS_OUT_CTRL, 8'h3c);
        phase();
        @(posedge clk_in);
        #1;
        check("outputs auto", {8'h0, on_out}, 16'h0003);
        end_of_test();
    end
endmodule
